/* src/rbt_pkg.sv */
`default_nettype none
package rbt_pkg;
  localparam int RBT_WORD_W = 32;
  localparam int RBT_BLOCK_WORDS = 4;
  localparam logic [2:0] RBT_QUAD_COUNT = 3'h4;
  localparam logic [2:0] RBT_SINGLE_COUNT = 3'h1;
  localparam logic [2:0] RBT_COUNT_ZERO = 3'h0;
  localparam logic [2:0] RBT_COUNT_STEP = 3'h1;
  localparam logic [1:0] RBT_FIRST_WORD = 2'h0;
  localparam logic [1:0] RBT_LAST_WORD = 2'h3;
  localparam logic [1:0] RBT_WORD_STEP = 2'h1;

  typedef enum logic [1:0] {
    RBT_SRC_UNCACHED = 2'b00,
    RBT_SRC_DCACHE   = 2'b01,
    RBT_SRC_ICACHE   = 2'b10
  } rbt_src_t;

  typedef enum logic [1:0] {
    RBT_CYC_NONE   = 2'b00,
    RBT_CYC_REFILL = 2'b01,
    RBT_CYC_FIXUP  = 2'b10,
    RBT_CYC_STREAM = 2'b11
  } rbt_cyc_t;

  typedef struct packed {
    logic       quad;
    rbt_src_t   src;
    logic [1:0] miss_word;
  } rbt_req_t;

  typedef struct packed {
    rbt_cyc_t   kind;
    logic [1:0] idx;
  } rbt_slot_t;

  typedef struct packed {
    logic                  valid;
    rbt_cyc_t              kind;
    logic [1:0]            idx;
    logic [RBT_WORD_W-1:0] data;
  } rbt_drain_t;
endpackage
`default_nettype wire

/* src/rbt_read_buf.sv */
`timescale 1ns/1ps
`default_nettype none
module rbt_read_buf (
  input  wire logic                            clk_sys,
  input  wire logic                            reset,
  input  wire logic                            clr,
  input  wire logic                            wr_en,
  input  wire logic [1:0]                      wr_idx,
  input  wire logic [rbt_pkg::RBT_WORD_W-1:0]  wr_data,
  input  wire logic [1:0]                      rd_idx,
  output logic      [rbt_pkg::RBT_WORD_W-1:0]  rd_data,
  output logic      [rbt_pkg::RBT_BLOCK_WORDS-1:0] avail
);
  logic [rbt_pkg::RBT_WORD_W-1:0] mem_q [rbt_pkg::RBT_BLOCK_WORDS];

  for (genvar i = 0; i < rbt_pkg::RBT_BLOCK_WORDS; i++) begin : g_word
    always_ff @(posedge clk_sys) begin
      if (reset || clr) begin
        avail[i] <= 1'b0;
      end else if (wr_en && wr_idx == 2'(i)) begin
        avail[i] <= 1'b1;
      end
    end
    always_ff @(posedge clk_sys) begin
      if (wr_en && wr_idx == 2'(i)) begin
        mem_q[i] <= wr_data;
      end
    end
  end

  assign rd_data = mem_q[rd_idx];
endmodule // rbt_read_buf
`default_nettype wire

/* src/rbt_drain_seq.sv */
`timescale 1ns/1ps
`default_nettype none
module rbt_drain_seq (
  input  wire logic               clk_sys,
  input  wire logic               reset,
  input  wire logic               start,
  input  wire logic               abort,
  input  wire logic               exec_stop,
  input  wire rbt_pkg::rbt_req_t  req,
  input  wire logic [3:0]         avail,
  output rbt_pkg::rbt_slot_t      slot,
  output logic                    slot_valid,
  output logic                    busy
);
  typedef enum logic [1:0] {
    RBT_SEQ_IDLE = 2'b00,
    RBT_SEQ_RUN  = 2'b01,
    RBT_SEQ_FIX  = 2'b10
  } rbt_seq_t;

  rbt_seq_t   state_q;
  logic [1:0] idx_q;
  logic       stop_q;
  logic [1:0] last_idx;

  always_comb begin
    last_idx   = req.quad ? rbt_pkg::RBT_LAST_WORD : rbt_pkg::RBT_FIRST_WORD;
    slot_valid = 1'b0;
    slot.kind  = rbt_pkg::RBT_CYC_NONE;
    slot.idx   = idx_q;
    unique case (state_q)
      RBT_SEQ_IDLE: ;
      RBT_SEQ_RUN: begin
        // waits for the word: memory is expected to stay ahead of us
        if (avail[idx_q]) begin
          slot_valid = 1'b1;
          if (req.src == rbt_pkg::RBT_SRC_UNCACHED) begin
            slot.kind = rbt_pkg::RBT_CYC_FIXUP;
          end else if (req.src == rbt_pkg::RBT_SRC_DCACHE) begin
            slot.kind = rbt_pkg::RBT_CYC_REFILL;
          end else if (idx_q < req.miss_word) begin
            slot.kind = rbt_pkg::RBT_CYC_REFILL;
          end else if (idx_q == req.miss_word) begin
            slot.kind = rbt_pkg::RBT_CYC_FIXUP;
          end else if (stop_q || exec_stop) begin
            slot.kind = rbt_pkg::RBT_CYC_REFILL;
          end else begin
            slot.kind = rbt_pkg::RBT_CYC_STREAM;
          end
        end
      end
      RBT_SEQ_FIX: begin
        slot_valid = 1'b1;
        slot.kind  = rbt_pkg::RBT_CYC_FIXUP;
        slot.idx   = last_idx == rbt_pkg::RBT_FIRST_WORD ? rbt_pkg::RBT_FIRST_WORD : req.miss_word;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset || abort) begin
      state_q <= RBT_SEQ_IDLE;
      idx_q   <= rbt_pkg::RBT_FIRST_WORD;
      stop_q  <= 1'b0;
    end else begin
      unique case (state_q)
        RBT_SEQ_IDLE: if (start) begin
          state_q <= RBT_SEQ_RUN;
          idx_q   <= rbt_pkg::RBT_FIRST_WORD;
          stop_q  <= 1'b0;
        end
        RBT_SEQ_RUN: if (slot_valid) begin
          // once streaming has stopped it stays stopped for this block
          stop_q <= stop_q || (exec_stop && idx_q > req.miss_word);
          if (req.src == rbt_pkg::RBT_SRC_UNCACHED || idx_q == last_idx) begin
            state_q <= req.src == rbt_pkg::RBT_SRC_DCACHE ? RBT_SEQ_FIX : RBT_SEQ_IDLE;
          end else begin
            idx_q <= idx_q + rbt_pkg::RBT_WORD_STEP;
          end
        end
        RBT_SEQ_FIX: state_q <= RBT_SEQ_IDLE;
        default: state_q <= RBT_SEQ_IDLE;
      endcase
    end
  end

  assign busy = state_q != RBT_SEQ_IDLE;
endmodule // rbt_drain_seq
`default_nettype wire

/* src/rbt_read_term.sv */
`timescale 1ns/1ps
`default_nettype none
module rbt_read_term (
  input  wire logic                            clk_sys,
  input  wire logic                            reset,
  input  wire logic                            rd_req,
  input  wire rbt_pkg::rbt_req_t               rd_req_info,
  input  wire logic                            exec_stop,
  input  wire logic [rbt_pkg::RBT_WORD_W-1:0]  ad_in,
  input  wire logic                            read_capture_enable_n,
  input  wire logic                            ack_n,
  input  wire logic                            bus_fault_in_n,
  output logic                                 rd_ready_q,
  output logic                                 core_stall_q,
  output logic                                 rd_strobe_n_q,
  output logic                                 data_output_enable_n_q,
  output logic                                 burst_sel_n_q,
  output logic                                 next_op_ok_q,
  output logic                                 fault_pulse_q,
  output rbt_pkg::rbt_drain_t                  drain_q
);
  typedef enum logic [1:0] {
    RBT_BUS_IDLE = 2'b00,
    RBT_BUS_ADDR = 2'b01,
    RBT_BUS_DATA = 2'b10,
    RBT_BUS_TURN = 2'b11
  } rbt_bus_t;

  rbt_bus_t                       state_q;
  rbt_bus_t                       state_d;
  rbt_pkg::rbt_req_t              req_q;
  logic [2:0]                     words_q;
  logic                           ack_seen_q;
  logic                           accept;
  logic                           in_data;
  logic                           cap;
  logic                           ack_in;
  logic                           fault_in;
  logic [2:0]                     need;
  logic                           last_word;
  logic                           fault_hit;
  logic                           ack_now;
  logic                           end_read;
  rbt_pkg::rbt_slot_t             slot;
  logic                           slot_valid;
  logic                           seq_busy;
  logic [rbt_pkg::RBT_WORD_W-1:0] buf_data;
  logic [3:0]                     avail;

  assign accept    = rd_req && rd_ready_q && state_q == RBT_BUS_IDLE;
  assign in_data   = state_q == RBT_BUS_DATA;
  assign cap       = in_data && !read_capture_enable_n;
  assign ack_in    = in_data && !ack_n;
  assign fault_in  = in_data && !bus_fault_in_n;
  assign need      = req_q.quad ? rbt_pkg::RBT_QUAD_COUNT : rbt_pkg::RBT_SINGLE_COUNT;
  assign last_word = cap && (words_q + rbt_pkg::RBT_COUNT_STEP) == need;
  assign fault_hit = fault_in && !ack_seen_q;
  assign ack_now   = !ack_seen_q && !fault_hit && (ack_in || last_word);
  assign end_read  = fault_hit || last_word;

  // bus sequencing; idle in data phase simply waits
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      RBT_BUS_IDLE: if (accept) state_d = RBT_BUS_ADDR;
      RBT_BUS_ADDR: state_d = RBT_BUS_DATA;
      RBT_BUS_DATA: if (end_read) state_d = RBT_BUS_TURN;
      RBT_BUS_TURN: state_d = RBT_BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_q <= RBT_BUS_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      req_q <= '0;
    end else if (accept) begin
      req_q <= rd_req_info;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset || accept) begin
      words_q <= rbt_pkg::RBT_COUNT_ZERO;
    end else if (cap && !fault_hit && words_q != need) begin
      words_q <= words_q + rbt_pkg::RBT_COUNT_STEP;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset || accept) begin
      ack_seen_q <= 1'b0;
    end else if (ack_now) begin
      ack_seen_q <= 1'b1;
    end
  end

  // read strobe stays low until the last word or a fault
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rd_strobe_n_q <= 1'b1;
    end else if (accept) begin
      rd_strobe_n_q <= 1'b0;
    end else if (end_read) begin
      rd_strobe_n_q <= 1'b1;
    end
  end

  // high through addressing so no memory fights our address drive
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      data_output_enable_n_q <= 1'b1;
    end else if (state_q == RBT_BUS_ADDR) begin
      data_output_enable_n_q <= 1'b0;
    end else if (end_read) begin
      data_output_enable_n_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      burst_sel_n_q <= 1'b1;
    end else if (accept) begin
      burst_sel_n_q <= !rd_req_info.quad;
    end else if (state_q == RBT_BUS_TURN) begin
      burst_sel_n_q <= 1'b1;
    end
  end

  // the core cannot issue a read in the cycle after termination
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rd_ready_q <= 1'b0;
    end else begin
      rd_ready_q <= state_d == RBT_BUS_IDLE && state_q != RBT_BUS_DATA && !accept
                    && !seq_busy && !ack_now;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      next_op_ok_q <= 1'b0;
    end else begin
      next_op_ok_q <= in_data && end_read;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      core_stall_q <= 1'b0;
    end else if (accept) begin
      core_stall_q <= 1'b1;
    end else if (ack_now || fault_hit) begin
      core_stall_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      fault_pulse_q <= 1'b0;
    end else begin
      fault_pulse_q <= fault_hit;
    end
  end

  // capture is modelled on the sampling edge itself, one cycle resolution
  rbt_read_buf u_buf (
    .clk_sys (clk_sys),
    .reset   (reset),
    .clr     (accept || fault_hit),
    .wr_en   (cap && !fault_hit && words_q != need),
    .wr_idx  (req_q.quad ? words_q[1:0] : rbt_pkg::RBT_FIRST_WORD),
    .wr_data (ad_in),
    .rd_idx  (slot.idx),
    .rd_data (buf_data),
    .avail   (avail)
  );

  rbt_drain_seq u_seq (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .start      (ack_now),
    .abort      (fault_hit),
    .exec_stop  (exec_stop),
    .req        (req_q),
    .avail      (avail),
    .slot       (slot),
    .slot_valid (slot_valid),
    .busy       (seq_busy)
  );

  always_ff @(posedge clk_sys) begin
    if (reset || fault_hit) begin
      drain_q <= '0;
    end else begin
      drain_q.valid <= slot_valid;
      drain_q.kind  <= slot.kind;
      drain_q.idx   <= slot.idx;
      drain_q.data  <= buf_data;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  reset_idle_a: assert property (@(posedge clk_sys) disable iff (1'b0)
    reset |=> state_q == RBT_BUS_IDLE && rd_strobe_n_q && data_output_enable_n_q && words_q == 3'h0)
    else $error("reset does not return to idle");

  no_read_turn_a: assert property (state_q == RBT_BUS_TURN |-> !rd_ready_q && !accept)
    else $error("read accepted right after termination");

  next_op_a: assert property (in_data && end_read |=> next_op_ok_q ##1 state_q == RBT_BUS_IDLE)
    else $error("bus not freed after termination");

  ack_window_a: assert property (accept |=> state_q == RBT_BUS_ADDR ##1 in_data && !rd_strobe_n_q)
    else $error("acknowledge window not one cycle after strobe");

  strobe_release_a: assert property (end_read |=> rd_strobe_n_q && data_output_enable_n_q)
    else $error("strobe or output enable not negated at termination");

  enable_addr_a: assert property (state_q == RBT_BUS_ADDR |-> data_output_enable_n_q)
    else $error("output enable active during addressing");

  strobe_hold_a: assert property (in_data && !end_read |=> !rd_strobe_n_q && in_data)
    else $error("strobe dropped while words expected");

  wait_hold_a: assert property (in_data && read_capture_enable_n && ack_n && bus_fault_in_n
    |=> in_data && $stable(words_q) && core_stall_q == !ack_seen_q)
    else $error("read advanced without capture or acknowledge");

  stall_drain_a: assert property (core_stall_q |-> !drain_q.valid)
    else $error("drain during stall");

  capture_count_a: assert property (cap && !fault_hit && words_q != need
    |=> words_q == $past(words_q) + 3'h1)
    else $error("captured word not counted");

  implicit_ack_a: assert property (last_word && !fault_hit |=> ack_seen_q && !core_stall_q)
    else $error("last capture does not acknowledge");

  fault_wins_a: assert property (fault_in && ack_in && !ack_seen_q
    |=> fault_pulse_q && !ack_seen_q && state_q == RBT_BUS_TURN)
    else $error("acknowledge beat fault");

  fault_ignore_a: assert property (fault_in && ack_seen_q |=> !fault_pulse_q)
    else $error("late fault not ignored");

  fault_stop_a: assert property (fault_hit |=> rd_strobe_n_q ##1 state_q == RBT_BUS_IDLE)
    else $error("fault did not end read");

  fault_clean_a: assert property (fault_pulse_q |-> !drain_q.valid ##1 !drain_q.valid)
    else $error("faulted read reached cache");

  burst_sel_a: assert property (state_q == RBT_BUS_ADDR |-> burst_sel_n_q == !req_q.quad)
    else $error("burst select wrong polarity");

  uncached_fix_a: assert property (drain_q.valid && req_q.src == rbt_pkg::RBT_SRC_UNCACHED
    |-> drain_q.kind == rbt_pkg::RBT_CYC_FIXUP ##1 !drain_q.valid)
    else $error("uncached drain not a single fixup");

  dcache_kind_a: assert property (drain_q.valid && req_q.src == rbt_pkg::RBT_SRC_DCACHE
    |-> drain_q.kind != rbt_pkg::RBT_CYC_STREAM)
    else $error("data refill streamed");

  iref_order_a: assert property (drain_q.valid && req_q.src == rbt_pkg::RBT_SRC_ICACHE
    && drain_q.idx < req_q.miss_word |-> drain_q.kind == rbt_pkg::RBT_CYC_REFILL)
    else $error("instruction refill order wrong");

  stop_refill_a: assert property (slot_valid && exec_stop && req_q.src == rbt_pkg::RBT_SRC_ICACHE
    && slot.idx > req_q.miss_word |=> drain_q.kind == rbt_pkg::RBT_CYC_REFILL)
    else $error("streaming continued after stop");

  zero_wait_c: cover property (accept ##2 (!ack_n && last_word) ##1 core_stall_q == 1'b0);

  fast_burst_c: cover property (accept && rd_req_info.quad ##2 (cap && ack_in) ##1 cap [*3]);

  fault_block_c: cover property (in_data && req_q.quad && words_q == 3'h2 && fault_hit);

  stream_c: cover property (drain_q.valid && drain_q.kind == rbt_pkg::RBT_CYC_STREAM);
endmodule // rbt_read_term
`default_nettype wire

/* tb/rbt_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rbt_mem_model (
  input  wire logic        clk_sys,
  input  wire logic        rd_strobe_n_q,
  input  wire logic        burst_sel_n_q,
  input  wire logic [3:0]  wait_cyc,
  input  wire logic [3:0]  gap_cyc,
  input  wire logic [1:0]  ack_mode,
  input  wire logic [2:0]  fault_word,
  input  wire logic [31:0] data_base,
  output logic      [31:0] ad_in,
  output logic             read_capture_enable_n,
  output logic             ack_n,
  output logic             bus_fault_in_n
);
  int   need;
  logic early;

  task automatic step();
    @(posedge clk_sys);
    #1;
  endtask

  initial begin
    ad_in = 32'h0000_0000;
    read_capture_enable_n = 1'b1;
    ack_n = 1'b1;
    bus_fault_in_n = 1'b1;
    forever begin
      step();
      if (!rd_strobe_n_q) begin
        need = burst_sel_n_q ? 1 : 4;
        early = (ack_mode == 2'h1);
        // address cycle: the bus turns around before the first sample
        step();
        for (int i = 0; i < need; i++) begin
          if (i == 0) begin
            repeat (wait_cyc) step();
          end else if (gap_cyc != 4'h0) begin
            read_capture_enable_n = 1'b1;
            ack_n = 1'b1;
            bus_fault_in_n = 1'b1;
            ad_in = ~ad_in;
            repeat (gap_cyc) step();
          end
          bus_fault_in_n = (fault_word != 3'(i));
          // fault before any ack ends the read, so no capture goes with it
          if (!bus_fault_in_n && !(early && i > 0)) begin
            if (i > 0 && gap_cyc == 4'h0) read_capture_enable_n = 1'b1;
            ack_n = !early;
            step();
            break;
          end
          ad_in = data_base ^ 32'(i);
          read_capture_enable_n = 1'b0;
          ack_n = !((early && i == 0) || (ack_mode == 2'h2 && i == need - 1)
                  || (ack_mode == 2'h3 && i == need - 2));
          step();
        end
        read_capture_enable_n = 1'b1;
        ack_n = 1'b1;
        bus_fault_in_n = 1'b1;
        // no pull-up: released bus shows the inverse, never a stale word
        ad_in = ~ad_in;
        while (!rd_strobe_n_q) step();
      end
    end
  end
endmodule // rbt_mem_model
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic                clk_sys, reset, rd_req, exec_stop;
  rbt_pkg::rbt_req_t   rd_req_info;
  logic [31:0]         ad_in, data_base;
  logic                read_capture_enable_n, ack_n, bus_fault_in_n;
  logic                rd_ready_q, core_stall_q, rd_strobe_n_q, data_output_enable_n_q;
  logic                burst_sel_n_q, next_op_ok_q, fault_pulse_q;
  rbt_pkg::rbt_drain_t drain_q;
  logic [3:0]          wait_cyc, gap_cyc;
  logic [1:0]          ack_mode;
  logic [2:0]          fault_word;
  logic                cur_quad, stop_arm;
  logic [35:0]         got[$];
  logic [35:0]         exp[$];
  int                  fails, num_checks, ncap;
  logic                t1, t2, f1, a1, acked, done, prev_low, term, flt;

  rbt_read_term u_rbt_read_term (.clk_sys(clk_sys), .reset(reset), .rd_req(rd_req),
    .rd_req_info(rd_req_info), .exec_stop(exec_stop), .ad_in(ad_in),
    .read_capture_enable_n(read_capture_enable_n), .ack_n(ack_n), .bus_fault_in_n(bus_fault_in_n),
    .rd_ready_q(rd_ready_q), .core_stall_q(core_stall_q), .rd_strobe_n_q(rd_strobe_n_q),
    .data_output_enable_n_q(data_output_enable_n_q), .burst_sel_n_q(burst_sel_n_q),
    .next_op_ok_q(next_op_ok_q), .fault_pulse_q(fault_pulse_q), .drain_q(drain_q));

  rbt_mem_model u_rbt_mem_model (.clk_sys(clk_sys), .rd_strobe_n_q(rd_strobe_n_q),
    .burst_sel_n_q(burst_sel_n_q), .wait_cyc(wait_cyc), .gap_cyc(gap_cyc), .ack_mode(ack_mode),
    .fault_word(fault_word), .data_base(data_base), .ad_in(ad_in),
    .read_capture_enable_n(read_capture_enable_n), .ack_n(ack_n), .bus_fault_in_n(bus_fault_in_n));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    num_checks++;
    if (seen !== want) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask

  task automatic finish_test();
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic step();
    @(posedge clk_sys);
    #1;
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    while (rd_ready_q !== 1'b1 && n < 200) begin
      step();
      n++;
    end
    check(rd_ready_q, 1'b1);
  endtask

  function automatic logic [35:0] ent(input rbt_pkg::rbt_cyc_t k, input logic [1:0] x);
    return {k, x, data_base ^ {30'h0000_0000, x}};
  endfunction

  task automatic cmp_drain();
    check(64'(got.size()), 64'(exp.size()));
    foreach (exp[i]) check(64'(got[i]), 64'(exp[i]));
  endtask

  // one read end to end; drain entries collect in got
  task automatic do_read(input logic q, input rbt_pkg::rbt_src_t s, input logic [1:0] m,
                         input logic [3:0] w, input logic [3:0] g, input logic [1:0] am,
                         input logic [2:0] fw);
    wait_ready();
    got.delete();
    wait_cyc = w;
    gap_cyc = g;
    ack_mode = am;
    fault_word = fw;
    cur_quad = q;
    data_base = data_base + 32'h0101_0010;
    rd_req_info = '{quad: q, src: s, miss_word: m};
    rd_req = 1'b1;
    step();
    rd_req = 1'b0;
    step();
    wait_ready();
  endtask

  // bus-side timing judged every cycle; outputs answer one edge after the sample
  always @(negedge clk_sys) begin
    if (reset) begin
      {t1, t2, f1, a1, acked, done, prev_low} = '0;
      ncap = 0;
    end else begin
      check(next_op_ok_q, t1);
      check(fault_pulse_q, f1);
      if (t2) check(rd_strobe_n_q, 1'b1);
      if (t1) begin
        check({rd_strobe_n_q, data_output_enable_n_q, core_stall_q}, 3'h6);
      end else if (prev_low) begin
        check(rd_strobe_n_q, 1'b0);
      end
      if (!rd_strobe_n_q) begin
        check(core_stall_q, !a1);
        check(burst_sel_n_q, !cur_quad);
      end
      if (drain_q.valid === 1'b1) got.push_back({drain_q.kind, drain_q.idx, drain_q.data});
      term = 1'b0;
      flt = 1'b0;
      if (!rd_strobe_n_q && !done) begin
        flt = !bus_fault_in_n && !acked;
        if (!flt && !read_capture_enable_n) ncap++;
        term = flt || ncap == (cur_quad ? 4 : 1);
        acked = acked || (!flt && (!ack_n || term));
        done = term;
      end else if (rd_strobe_n_q) begin
        done = 1'b0;
        acked = 1'b0;
        ncap = 0;
      end
      t2 = t1;
      t1 = term;
      f1 = flt;
      a1 = acked;
      prev_low = !rd_strobe_n_q;
    end
  end

  // execution halts right after the first stream cycle
  always @(posedge clk_sys) begin
    #1;
    if (stop_arm && drain_q.valid === 1'b1 && drain_q.kind === rbt_pkg::RBT_CYC_STREAM) exec_stop = 1'b1;
  end

  task automatic t_zero_single();
    do_read(1'b0, rbt_pkg::RBT_SRC_UNCACHED, 2'h0, 4'h0, 4'h0, 2'h1, 3'h4);
    exp = '{ent(rbt_pkg::RBT_CYC_FIXUP, 2'h0)};
    cmp_drain();
  endtask

  task automatic t_wait_single();
    do_read(1'b0, rbt_pkg::RBT_SRC_DCACHE, 2'h0, 4'h2, 4'h0, 2'h2, 3'h4);
    exp = '{ent(rbt_pkg::RBT_CYC_REFILL, 2'h0), ent(rbt_pkg::RBT_CYC_FIXUP, 2'h0)};
    cmp_drain();
  endtask

  task automatic t_quad_fast(input logic [1:0] am, input logic [2:0] fw, input logic [1:0] m);
    do_read(1'b1, rbt_pkg::RBT_SRC_DCACHE, m, 4'h0, 4'h0, am, fw);
    exp = {};
    for (int i = 0; i < 4; i++) exp.push_back(ent(rbt_pkg::RBT_CYC_REFILL, 2'(i)));
    exp.push_back(ent(rbt_pkg::RBT_CYC_FIXUP, m));
    cmp_drain();
  endtask

  task automatic t_icache();
    do_read(1'b1, rbt_pkg::RBT_SRC_ICACHE, 2'h2, 4'h1, 4'h1, 2'h0, 3'h4);
    exp = '{ent(rbt_pkg::RBT_CYC_REFILL, 2'h0), ent(rbt_pkg::RBT_CYC_REFILL, 2'h1),
            ent(rbt_pkg::RBT_CYC_FIXUP, 2'h2), ent(rbt_pkg::RBT_CYC_STREAM, 2'h3)};
    cmp_drain();
  endtask

  // slow words leave room for the stop to land before the last word
  task automatic t_stream_stop();
    stop_arm = 1'b1;
    do_read(1'b1, rbt_pkg::RBT_SRC_ICACHE, 2'h1, 4'h0, 4'h3, 2'h1, 3'h4);
    stop_arm = 1'b0;
    exp = '{ent(rbt_pkg::RBT_CYC_REFILL, 2'h0), ent(rbt_pkg::RBT_CYC_FIXUP, 2'h1),
            ent(rbt_pkg::RBT_CYC_STREAM, 2'h2), ent(rbt_pkg::RBT_CYC_REFILL, 2'h3)};
    cmp_drain();
    exec_stop = 1'b0;
  endtask

  // ack rides the third word so the last word lands just before the drain needs it
  task automatic t_throttle();
    do_read(1'b1, rbt_pkg::RBT_SRC_DCACHE, 2'h1, 4'h1, 4'h1, 2'h3, 3'h4);
    exp = {};
    for (int i = 0; i < 4; i++) exp.push_back(ent(rbt_pkg::RBT_CYC_REFILL, 2'(i)));
    exp.push_back(ent(rbt_pkg::RBT_CYC_FIXUP, 2'h1));
    cmp_drain();
  endtask

  task automatic t_fault(input logic q, input logic [1:0] am, input logic [2:0] fw);
    do_read(q, rbt_pkg::RBT_SRC_DCACHE, 2'h0, 4'h1, 4'h0, am, fw);
    exp = {};
    cmp_drain();
  endtask

  initial begin
    fails = 0;
    num_checks = 0;
    reset = 1'b1;
    rd_req = 1'b0;
    exec_stop = 1'b0;
    stop_arm = 1'b0;
    cur_quad = 1'b0;
    rd_req_info = '0;
    {wait_cyc, gap_cyc, ack_mode, fault_word} = '0;
    data_base = 32'h5a00_0000;
    repeat (6) step();
    check({rd_strobe_n_q, data_output_enable_n_q, burst_sel_n_q, core_stall_q}, 4'he);
    check({rd_ready_q, drain_q.valid, next_op_ok_q, fault_pulse_q}, 4'h0);
    reset = 1'b0;
    t_zero_single();
    t_wait_single();
    t_quad_fast(2'h1, 3'h4, 2'h2);
    t_icache();
    t_stream_stop();
    t_fault(1'b0, 2'h1, 3'h0);
    t_fault(1'b1, 2'h0, 3'h2);
    t_quad_fast(2'h1, 3'h2, 2'h3);
    t_throttle();
    repeat (4) step();
    finish_test();
  end

  // whole run is about a hundred cycles
  initial begin
    #100000;
    fails++;
    $display("watchdog expired at %0t", $time);
    finish_test();
  end
endmodule // testbench
`default_nettype wire
